// file: include/sbtap_pkg.sv
// constants and types of the sram boundary scan test access port
// assumes one test clock, the memory clocks arriving as plain levels
package sbtap_pkg;
    // ----------------------------------------------------------------
    // register lengths
    // ----------------------------------------------------------------
    localparam int BS_LEN = 109;
    localparam int ID_LEN = 32;
    localparam int IR_LEN = 3;
    // chain positions, bit number minus one
    localparam int BS_CELL_ECHO_T = 46;
    localparam int BS_CELL_ECHO_C = 64;
    localparam int BS_CELL_INT = 108;

    // ----------------------------------------------------------------
    // instruction codes
    // ----------------------------------------------------------------
    localparam logic [2:0] IR_EXTERNAL_TEST = 3'h0;
    localparam logic [2:0] IR_IDENTIFY = 3'h1;
    localparam logic [2:0] IR_SAMPLE_Z = 3'h2;
    localparam logic [2:0] IR_SAMPLE = 3'h4;
    localparam logic [2:0] IR_BYPASS = 3'h7;
    localparam logic [1:0] IR_CAPTURE_VAL = 2'h1;

    // ----------------------------------------------------------------
    // identification value fields
    // ----------------------------------------------------------------
    localparam logic [2:0] DENS_72M = 3'h3;
    localparam logic [2:0] DENS_36M = 3'h2;
    localparam logic [2:0] DENS_18M = 3'h1;
    localparam logic [1:0] ORG_X36 = 2'h3;
    localparam logic [1:0] ORG_X18 = 2'h2;
    localparam logic [1:0] ORG_X9 = 2'h0;
    localparam logic [1:0] ORG_X8 = 2'h1;
    localparam logic BURST_FOUR = 1'h1;
    localparam logic BURST_TWO = 1'h0;
    localparam logic IO_SEPARATE = 1'h1;
    localparam logic IO_COMMON = 1'h0;
    localparam logic RATE_QUAD = 1'h1;
    localparam logic RATE_DOUBLE = 1'h0;
    localparam logic ID_START_BIT = 1'h1;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int TCK_MIN_NS = 100;
    localparam int TCK_CYCLES = (TCK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_TMS_EDGES = 5;

    // ----------------------------------------------------------------
    // controller states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [15:0] {
        ST_TLR = 16'h0001, ST_RTI = 16'h0002, ST_SDRS = 16'h0004, ST_CDR = 16'h0008,
        ST_SDR = 16'h0010, ST_E1DR = 16'h0020, ST_PDR = 16'h0040, ST_E2DR = 16'h0080,
        ST_UDR = 16'h0100, ST_SIRS = 16'h0200, ST_CIR = 16'h0400, ST_SIR = 16'h0800,
        ST_E1IR = 16'h1000, ST_PIR = 16'h2000, ST_E2IR = 16'h4000, ST_UIR = 16'h8000
    } sbtap_state_t;

    // memory clock balls
    typedef struct packed {
        logic k;
        logic k_n;
        logic c;
        logic c_n;
    } sbtap_clk_t;
endpackage

// file: core/sbtap_scan_chain.sv
// boundary scan register: capture, shift and update stages
// assumes the controller gives one-cycle capture and update strobes
`timescale 1ns/1ps
module sbtap_scan_chain (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // controls
    input wire logic capture_i,
    input wire logic shift_i,
    input wire logic update_i,
    input wire logic tdi_i,
    // parallel sides
    input wire logic [sbtap_pkg::BS_LEN-1:0] par_i,
    output logic [sbtap_pkg::BS_LEN-1:0] upd_o,
    output logic so_o
);
    import sbtap_pkg::*;

    logic [BS_LEN-1:0] sr_r;

    // ----------------------------------------------------------------
    // shift stage, cell one nearest the serial output
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sr_r <= '0;
        end else if (capture_i) begin
            sr_r <= par_i;
        end else if (shift_i) begin
            sr_r <= {tdi_i, sr_r[BS_LEN-1:1]};
        end
    end

    // update stage holds what the balls drive under external test
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            upd_o <= '0;
        end else if (update_i) begin
            upd_o <= sr_r;
        end
    end

    assign so_o = sr_r[0];

    shift_order_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (shift_i && !capture_i) |=> sr_r[BS_LEN-2:0] == $past(sr_r[BS_LEN-1:1]))
        else $error("scan chain did not shift toward the output");
endmodule

// file: core/sbtap_top.sv
// test access port of the sram: controller, instruction, id, bypass, echo clocks
// assumes clk_i is the test clock and tms/tdi meet setup before its rising edge
`timescale 1ns/1ps
// What this block does
// - boundary chain: one cell per ball in table order, last cell internal
// - id word: revision 31:29, type 28:12, vendor 11:1, one in bit 0
// - density subfield: 72M 011, 36M 010, 18M 001
// - organization subfield: x36 11, x18 10, x9 00, x8 01
// - type carries burst, io and rate-architecture bits
// - five rising edges with tms high always reach test logic reset
// - state moves on tms sampled at each rising test clock edge
// - echo clocks follow output clocks except external test and sample-z
// - output clocks both high: echo clocks follow input clocks instead
// - identify code 001 captures id word, default after reset
// - three-bit instruction; 111 bypass; 011, 101, 110 reserved
// - sample-z code 010 floats memory outputs, captures inputs
module sbtap_top #(
    parameter logic [2:0] REVISION = 3'h5,   // arbitrary value
    parameter logic [10:0] VENDOR = 11'h2A5, // arbitrary value
    parameter logic [2:0] DENSITY = sbtap_pkg::DENS_36M,
    parameter logic [1:0] ORGANIZATION = sbtap_pkg::ORG_X36,
    parameter logic BURST = sbtap_pkg::BURST_TWO,
    parameter logic IO_KIND = sbtap_pkg::IO_COMMON,
    parameter logic RATE = sbtap_pkg::RATE_DOUBLE
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // test port
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    // balls
    input wire logic [sbtap_pkg::BS_LEN-1:0] ball_in_i,
    input wire sbtap_pkg::sbtap_clk_t mem_clk_i,
    output logic [sbtap_pkg::BS_LEN-1:0] ball_out_o,
    output logic ext_test_drive_o,
    output logic mem_out_hiz_o,
    // echo clocks
    output logic echo_clock_true_o,
    output logic echo_clock_comp_o,
    output logic echo_clock_oe_o
);
    import sbtap_pkg::*;

    // ----------------------------------------------------------------
    // fixed identification value
    // ----------------------------------------------------------------
    localparam logic [16:0] TYPE_NUM = {2'h0, DENSITY, 1'h0, ORGANIZATION, 1'h0,
        1'h1, 1'h0, RATE, 1'h0, BURST, 1'h0, IO_KIND, 1'h0};
    localparam logic [31:0] ID_VALUE = {REVISION, TYPE_NUM, VENDOR, ID_START_BIT};

    sbtap_state_t state_r;
    sbtap_state_t state_nxt;
    logic [IR_LEN-1:0] ir_r;
    logic [IR_LEN-1:0] ir_sr_r;
    logic [ID_LEN-1:0] id_sr_r;
    logic bypass_r;
    logic bs_so;
    logic bs_sel;
    logic tdo_nxt;

    // ----------------------------------------------------------------
    // controller
    // ----------------------------------------------------------------
    function automatic sbtap_state_t next_state(sbtap_state_t s, logic tms);
        case (s)
            ST_TLR: next_state = tms ? ST_TLR : ST_RTI;
            ST_RTI: next_state = tms ? ST_SDRS : ST_RTI;
            ST_SDRS: next_state = tms ? ST_SIRS : ST_CDR;
            ST_CDR: next_state = tms ? ST_E1DR : ST_SDR;
            ST_SDR: next_state = tms ? ST_E1DR : ST_SDR;
            ST_E1DR: next_state = tms ? ST_UDR : ST_PDR;
            ST_PDR: next_state = tms ? ST_E2DR : ST_PDR;
            ST_E2DR: next_state = tms ? ST_UDR : ST_SDR;
            ST_UDR: next_state = tms ? ST_SDRS : ST_RTI;
            ST_SIRS: next_state = tms ? ST_TLR : ST_CIR;
            ST_CIR: next_state = tms ? ST_E1IR : ST_SIR;
            ST_SIR: next_state = tms ? ST_E1IR : ST_SIR;
            ST_E1IR: next_state = tms ? ST_UIR : ST_PIR;
            ST_PIR: next_state = tms ? ST_E2IR : ST_PIR;
            ST_E2IR: next_state = tms ? ST_UIR : ST_SIR;
            ST_UIR: next_state = tms ? ST_SDRS : ST_RTI;
            default: next_state = ST_TLR;
        endcase
    endfunction

    // reserved and unknown codes fall back to the bypass path
    function automatic logic is_bs(logic [IR_LEN-1:0] ir);
        is_bs = (ir == IR_EXTERNAL_TEST) || (ir == IR_SAMPLE_Z) || (ir == IR_SAMPLE);
    endfunction

    always_comb begin
        state_nxt = next_state(state_r, tms_i);
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= ST_TLR;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // instruction register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ir_sr_r <= '0;
        end else if (state_r == ST_CIR) begin
            ir_sr_r <= {1'h0, IR_CAPTURE_VAL};
        end else if (state_r == ST_SIR) begin
            ir_sr_r <= {tdi_i, ir_sr_r[IR_LEN-1:1]};
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ir_r <= IR_IDENTIFY;
        end else if (state_r == ST_TLR) begin
            ir_r <= IR_IDENTIFY;
        end else if (state_r == ST_UIR) begin
            ir_r <= ir_sr_r;
        end
    end

    // ----------------------------------------------------------------
    // id and bypass registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            id_sr_r <= '0;
        end else if (ir_r == IR_IDENTIFY && state_r == ST_CDR) begin
            id_sr_r <= ID_VALUE;
        end else if (ir_r == IR_IDENTIFY && state_r == ST_SDR) begin
            id_sr_r <= {tdi_i, id_sr_r[ID_LEN-1:1]};
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bypass_r <= 1'h0;
        end else if (state_r == ST_CDR) begin
            bypass_r <= 1'h0;
        end else if (state_r == ST_SDR) begin
            bypass_r <= tdi_i;
        end
    end

    // ----------------------------------------------------------------
    // boundary chain
    // ----------------------------------------------------------------
    logic [BS_LEN-1:0] bs_par;

    always_comb begin
        bs_par = ball_in_i;
        bs_par[BS_CELL_INT] = 1'h0;
    end

    assign bs_sel = is_bs(ir_r);

    sbtap_scan_chain u_chain (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .capture_i(bs_sel && state_r == ST_CDR),
        .shift_i(bs_sel && state_r == ST_SDR),
        .update_i(bs_sel && state_r == ST_UDR),
        .tdi_i(tdi_i),
        .par_i(bs_par),
        .upd_o(ball_out_o),
        .so_o(bs_so)
    );

    // ----------------------------------------------------------------
    // test data out on the falling edge
    // ----------------------------------------------------------------
    always_comb begin
        if (state_r == ST_SIR) begin
            tdo_nxt = ir_sr_r[0];
        end else if (ir_r == IR_IDENTIFY) begin
            tdo_nxt = id_sr_r[0];
        end else if (bs_sel) begin
            tdo_nxt = bs_so;
        end else begin
            tdo_nxt = bypass_r;
        end
    end

    // falling edge gives the board half a period of hold on tdo
    always_ff @(negedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tdo_o <= 1'h0;
            tdo_oe_o <= 1'h0;
        end else begin
            tdo_o <= tdo_nxt;
            tdo_oe_o <= (state_r == ST_SDR) || (state_r == ST_SIR);
        end
    end

    // ----------------------------------------------------------------
    // memory outputs and echo clocks
    // ----------------------------------------------------------------
    assign ext_test_drive_o = (ir_r == IR_EXTERNAL_TEST);
    assign mem_out_hiz_o = (ir_r == IR_SAMPLE_Z);
    assign echo_clock_oe_o = !mem_out_hiz_o;

    // echo clocks are clocks, so they stay a mux and are not retimed
    always_comb begin
        if (ext_test_drive_o) begin
            echo_clock_true_o = ball_out_o[BS_CELL_ECHO_T];
            echo_clock_comp_o = ball_out_o[BS_CELL_ECHO_C];
        end else if (mem_out_hiz_o) begin
            echo_clock_true_o = 1'h0;
            echo_clock_comp_o = 1'h0;
        end else if (mem_clk_i.c && mem_clk_i.c_n) begin
            echo_clock_true_o = mem_clk_i.k;
            echo_clock_comp_o = mem_clk_i.k_n;
        end else begin
            echo_clock_true_o = mem_clk_i.c;
            echo_clock_comp_o = mem_clk_i.c_n;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    tms_reset_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        tms_i [*5] |=> state_r == ST_TLR)
        else $error("five high tms edges did not reach reset state");
    ir_default_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        state_r == ST_TLR |=> ir_r == IR_IDENTIFY)
        else $error("identify not default after reset state");
    id_capture_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_r == ST_CDR && ir_r == IR_IDENTIFY) |=> id_sr_r == ID_VALUE)
        else $error("id value not captured");
    ir_update_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        state_r == ST_UIR |=> ir_r == $past(ir_sr_r))
        else $error("instruction not updated");
    step_rule_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_r == ST_SDR && !tms_i) |=> state_r == ST_SDR)
        else $error("shift state left with tms low");
    hiz_enter_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_r == ST_UIR && ir_sr_r == IR_SAMPLE_Z) |=> mem_out_hiz_o && !echo_clock_oe_o)
        else $error("sample-z did not float outputs");
    echo_follow_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (ir_r == IR_BYPASS && !(mem_clk_i.c && mem_clk_i.c_n))
        |-> echo_clock_true_o == mem_clk_i.c && echo_clock_comp_o == mem_clk_i.c_n)
        else $error("echo clocks not following output clocks");
    echo_input_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (ir_r == IR_IDENTIFY && mem_clk_i.c && mem_clk_i.c_n)
        |-> echo_clock_true_o == mem_clk_i.k && echo_clock_comp_o == mem_clk_i.k_n)
        else $error("echo clocks not following input clocks");
    id_shift_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state_r == ST_SDR && ir_r == IR_IDENTIFY) |-> tdo_oe_o && tdo_o == id_sr_r[0])
        else $error("tdo not showing id bit");

    id_read_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        state_r == ST_CDR && ir_r == IR_IDENTIFY ##1 state_r == ST_SDR);
    samplez_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        mem_out_hiz_o && state_r == ST_CDR);
    ext_test_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        ext_test_drive_o && state_r == ST_UDR);
endmodule

// file: verification/sbtap_jtag_model.sv
// board-side test controller model: drives tms, tdi and the memory clock balls
// assumes the bench checks tdo itself; every change lands just after a rising edge
`timescale 1ns/1ps
module sbtap_jtag_model (
    // clock
    input wire logic clk_i,
    // test port
    output logic tms_o,
    output logic tdi_o,
    // memory clock balls
    output sbtap_pkg::sbtap_clk_t mem_clk_o
);
    import sbtap_pkg::*;

    initial begin
        tms_o = 1'h1;
        tdi_o = 1'h0;
        mem_clk_o = 4'hA;
    end

    // ------------------------------------------------------------
    // edge level moves
    // ------------------------------------------------------------
    task automatic step(input logic t, input logic d);
        @(posedge clk_i);
        tms_o <= t;
        tdi_o <= d;
    endtask

    // idle tdi toggles so a stale bit never passes for shifted data
    task automatic walk(input logic [7:0] seq, input int n);
        for (int i = 0; i < n; i++) begin
            step(seq[i], ~tdi_o);
        end
    endtask

    // from run-test-idle: scan n bits lsb first, then back to run-test-idle
    task automatic scan(input logic ir, input logic [127:0] d, input int n);
        walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, d[i]);
        end
        walk(8'h01, 2);
    endtask

    // pairs stay opposite unless the output clocks are tied high
    task automatic set_clk(input logic k, input logic c, input logic tie);
        @(posedge clk_i);
        mem_clk_o <= '{k, ~k, c | tie, ~c | tie};
    endtask
endmodule

// file: verification/tb_top.sv
// self-checking bench of the sram test access port
// assumes the partner model drives the test port; tdo bits are checked from a queue
`timescale 1ns/1ps
module tb_top;
    import sbtap_pkg::*;
    localparam logic [2:0] REV = 3'h5;     // arbitrary value
    localparam logic [10:0] VEND = 11'h2A5; // arbitrary value
    logic clk_i = 1'h0;
    logic rst_b_i = 1'h0;
    logic tms, tdi, tdo_o, tdo_oe_o, ex_o, hiz_o, eq_o, ec_o, eoe_o;
    logic [BS_LEN-1:0] ball_in = '0;
    logic [BS_LEN-1:0] ball_out_o;
    sbtap_clk_t mem_clk;
    logic exp_q[$];
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h9C02F3A4;
    logic [127:0] pat;
    logic [127:0] bvec;
    logic [31:0] id_exp;
    logic [31:0] r;
    logic [2:0] codes[4] = '{3'h7, 3'h3, 3'h5, 3'h6};
    logic [2:0] bcode[2] = '{3'h4, 3'h2};

    always #50 clk_i = ~clk_i;

    sbtap_jtag_model i_ctrl (.clk_i(clk_i), .tms_o(tms), .tdi_o(tdi), .mem_clk_o(mem_clk));
    sbtap_top #(.REVISION(REV), .VENDOR(VEND), .DENSITY(DENS_72M), .ORGANIZATION(ORG_X18),
        .BURST(BURST_FOUR), .IO_KIND(IO_SEPARATE), .RATE(RATE_QUAD)) i_dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo_o),
        .tdo_oe_o(tdo_oe_o), .ball_in_i(ball_in), .mem_clk_i(mem_clk),
        .ball_out_o(ball_out_o), .ext_test_drive_o(ex_o), .mem_out_hiz_o(hiz_o),
        .echo_clock_true_o(eq_o), .echo_clock_comp_o(ec_o), .echo_clock_oe_o(eoe_o));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic fail(input string m);
        errors++;
        $display("[FAIL] %0t %s", $time, m);
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) fail("tdo bit differs");
    endtask

    task automatic chk_vec(input logic [127:0] got, input logic [127:0] exp, input string m);
        compares++;
        if (got !== exp) fail(m);
    endtask

    task automatic expect_bits(input logic [127:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(v[i]);
        end
    endtask

    // ir and update stage load on the edge that leaves the update state
    task automatic settle();
        repeat (2) @(negedge clk_i);
    endtask

    task automatic load_ir(input logic [2:0] code);
        expect_bits(128'h1, 3);
        i_ctrl.scan(1'h1, {125'h0, code}, 3);
        settle();
    endtask

    task automatic done(input string name);
        @(negedge clk_i);
        chk_vec(exp_q.size(), 0, "tdo bits missing");
        $display("test %s finished", name);
    endtask

    task automatic wrap_up();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // tdo watcher: one queued bit per edge with the output driven
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (tdo_oe_o === 1'h1) begin
            if (exp_q.size() == 0) fail("unexpected tdo bit");
            else chk_bit(tdo_o, exp_q.pop_front());
        end
    end

    initial begin
        wait (cycles == 3000);
        fail("timeout");
        wrap_up();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'h1;
        i_ctrl.walk(8'h00, 1);
        id_exp = {REV, 2'h0, 3'h3, 1'h0, 2'h2, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1,
            1'h0, 1'h1, 1'h0, VEND, 1'h1};
        expect_bits(id_exp, 32);
        i_ctrl.scan(1'h0, {4{rnd()}}, 32);
        done("identify after reset");
        foreach (codes[j]) begin
            load_ir(codes[j]);
            pat = {4{rnd()}};
            expect_bits({pat[126:0], 1'h0}, 20);
            i_ctrl.scan(1'h0, pat, 20);
        end
        done("bypass and reserved codes");
        // pause-dr is exactly five high edges away from test logic reset
        i_ctrl.walk(8'h05, 4);
        i_ctrl.walk(8'h1F, 6);
        expect_bits(id_exp, 32);
        i_ctrl.scan(1'h0, {4{rnd()}}, 32);
        done("reset by tms");
        foreach (bcode[j]) begin
            load_ir(bcode[j]);
            chk_vec({hiz_o, eoe_o}, {bcode[j] == 3'h2, bcode[j] != 3'h2}, "float");
            pat = {4{rnd()}};
            @(posedge clk_i);
            ball_in <= pat[108:0];
            expect_bits({20'h0, pat[107:0]}, 109);
            bvec = {4{rnd()}};
            i_ctrl.scan(1'h0, bvec, 109);
            settle();
            chk_vec(ball_out_o[107:0], bvec[107:0], "update stage");
        end
        chk_vec({eq_o, ec_o}, 2'h0, "echo under sample-z");
        done("boundary capture and update");
        load_ir(3'h0);
        // echo balls sit at bit numbers 47 and 65
        chk_vec({ex_o, hiz_o, eoe_o, eq_o, ec_o}, {3'h5, bvec[46], bvec[64]}, "external test");
        load_ir(3'h1);
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            i_ctrl.set_clk(r[0], r[1], r[2]);
            @(negedge clk_i);
            chk_vec({eq_o, ec_o}, r[2] ? {r[0], ~r[0]} : {r[1], ~r[1]}, "echo");
        end
        done("echo clocks");
        wrap_up();
    end
endmodule
